// File: verilog/pcr_pkg.sv
// Package with offsets, field layouts, reset values and scale constants of the protection bank.
package pcr_pkg;

  // Byte addresses of the bank on the register port.
  localparam logic [7:0] ZC_TRIM_ADDR   = 8'h4d;
  localparam logic [7:0] GATE_CFG_ADDR  = 8'h4e;
  localparam logic [7:0] OV_CFG_ADDR    = 8'h4f;
  localparam logic [7:0] UV_CFG_ADDR    = 8'h50;
  localparam logic [7:0] TEMP_WARN_ADDR = 8'h51;
  localparam logic [7:0] CLEAR_ADDR     = 8'h52;
  localparam logic [7:0] AUX_CFG_ADDR   = 8'h53;

  // Implemented bits of each register; everything else reads zero.
  localparam logic [7:0] ZC_TRIM_MASK   = 8'h3f;
  localparam logic [7:0] GATE_CFG_MASK  = 8'h3f;
  localparam logic [7:0] OV_CFG_MASK    = 8'h07;
  localparam logic [7:0] UV_CFG_MASK    = 8'h07;
  localparam logic [7:0] TEMP_WARN_MASK = 8'hff;
  localparam logic [7:0] CLEAR_MASK     = 8'h01;
  localparam logic [7:0] AUX_CFG_MASK   = 8'h0e;

  // Field positions.
  localparam int ZC_SIGN_BIT      = 5;
  localparam int GATE_EN_BIT      = 0;
  localparam int GATE_CODE_LSB    = 1;
  localparam int CLEAR_BIT        = 0;
  localparam int AUX_TIMER_BIT    = 3;
  localparam int AUX_SOURCE_BIT   = 2;
  localparam int AUX_TRIGGER_BIT  = 1;

  // Reset values.
  localparam logic [7:0] ZC_TRIM_RST    = 8'h00;
  localparam logic [7:0] GATE_CFG_RST   = 8'h00;
  localparam logic [7:0] OV_CFG_RST     = 8'h00;
  localparam logic [7:0] UV_CFG_RST     = 8'h00;
  localparam logic [7:0] TEMP_WARN_RST  = 8'hff;
  localparam logic [7:0] CLEAR_RST      = 8'h00;
  localparam logic [7:0] AUX_CFG_RST    = 8'h00;

  // Scale constants: 600 uV, 35 mV, 215 mV, 50 mV, 8 mV.
  localparam logic [15:0]        ZC_STEP_UV     = 16'h0258;
  localparam logic [10:0]        GATE_STEP_MV   = 11'h023;
  localparam logic [10:0]        GATE_BASE_MV   = 11'h0d7;
  localparam logic [11:0]        THR_STEP_MV    = 12'h032;
  localparam logic [11:0]        TEMP_STEP_MV   = 12'h008;
  // Over-voltage nominal 600 mV typical, 500 mV minimum, clamp 2000 mV.
  localparam logic signed [11:0] OV_TYP_MV      = 12'sh258;
  localparam logic signed [11:0] OV_MIN_MV      = 12'sh1f4;
  localparam logic signed [11:0] OV_CLAMP_MV    = 12'sh7d0;
  localparam logic [2:0]         OV_CLAMP_CODE  = 3'h4;
  // Under-voltage nominal -500 mV typical, bounded at -400 mV.
  localparam logic signed [11:0] UV_TYP_MV      = -12'sh1f4;
  localparam logic signed [11:0] UV_BOUND_MV    = -12'sh190;
  localparam logic [2:0]         UV_OFF_CODE    = 3'h4;
  // Current-limit trigger levels: 225 mV and 1000 mV.
  localparam logic signed [12:0] LIMIT_LOW_MV   = 13'sh0e1;
  localparam logic signed [12:0] LIMIT_DIFF_MV  = 13'sh3e8;

endpackage : pcr_pkg

// File: verilog/pcr_protection_config_registers.sv
// Protection configuration register bank with its derived threshold and gate logic.
//
// Notes on behaviour
// - Trim bits 5:0 give 0.6 mV steps; bit 5 set positive, else negative.
// - Gate threshold bits 5:1 map 0.215 V plus 35 mV per code.
// - Gate enable bit 0 resets to 0 and a 1 enables the gate.
// - Enabled gate blocks per-phase current limiting while output is below threshold.
// - Over-voltage code shifts the trip by 50 mV steps up or down.
// - Over-voltage code 000 gives 600 mV typical, 500 mV minimum.
// - Over-voltage code 100 clamps the trip level at a fixed 2.0 V.
// - Under-voltage code shifts by 50 mV steps; code 100 disables protection.
// - Under-voltage code 000 gives -500 mV typical, bounded at -400 mV.
// - Temperature warning threshold resets to 0xff, 8 mV per code.
// - Writing bit 0 from 0 to 1 clears the overcurrent limit status.
// - The clear register stays writable while the lock rejects other writes.
// - Auxiliary bit 3 enables the ultrasonic timer, reset value 0.
// - Auxiliary bit 2 picks fuse settings at 0, bus settings at 1.
// - Auxiliary bit 1 picks low-level trigger or reference-difference trigger.
`timescale 1ns/1ps

module pcr_protection_config_registers
  import pcr_pkg::*;
#(
  parameter int NPHASE = 8
) (
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                reg_wr_en,
  input  wire logic                reg_rd_en,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  input  wire logic                reg_lock,
  input  wire logic [10:0]         vout_rel_diff_amp_output_mv,
  input  wire logic [NPHASE-1:0]   per_phase_current_limit_raw,
  input  wire logic [7:0]          power_stage_temp_monitor_code,
  input  wire logic [11:0]         current_sense_amp_out_mv,
  input  wire logic [11:0]         current_sense_reference_mv,
  output logic [7:0]               reg_rdata,
  output logic                     reg_rd_valid,
  output logic signed [15:0]       zero_cross_detector_offset_uv,
  output logic [10:0]              min_vout_limit_gate_mv,
  output logic                     min_vout_limit_gate_active,
  output logic [NPHASE-1:0]        per_phase_current_limit,
  output logic signed [11:0]       overvoltage_protection_typ_mv,
  output logic signed [11:0]       overvoltage_protection_min_mv,
  output logic                     overvoltage_protection_clamped,
  output logic signed [11:0]       undervoltage_protection_typ_mv,
  output logic signed [11:0]       undervoltage_protection_bound_mv,
  output logic                     undervoltage_protection_enable,
  output logic [11:0]              power_stage_temp_warn_mv,
  output logic                     power_stage_temp_warning,
  output logic                     overcurrent_limit_status_clear,
  output logic                     ultrasonic_timer_enable,
  output logic                     settings_from_i2c,
  output logic                     limit_trigger_select,
  output logic                     current_limit_event
);

  // The whole state of the bank, software fields and registered outputs alike.
  typedef struct packed {
    logic [5:0]          zc_trim;
    logic [4:0]          gate_code;
    logic                gate_en;
    logic [2:0]          ov_code;
    logic [2:0]          uv_code;
    logic [7:0]          temp_thr;
    logic                clear_bit;
    logic                aux_timer;
    logic                aux_source;
    logic                aux_trigger;
    logic [7:0]          rdata;
    logic                rd_valid;
    logic signed [15:0]  zc_offset_uv;
    logic [10:0]         gate_mv;
    logic                gate_active;
    logic [NPHASE-1:0]   phase_limit;
    logic signed [11:0]  ov_typ_mv;
    logic signed [11:0]  ov_min_mv;
    logic                ov_clamped;
    logic signed [11:0]  uv_typ_mv;
    logic signed [11:0]  uv_bound_mv;
    logic                uv_enable;
    logic [11:0]         temp_mv;
    logic                temp_warning;
    logic                status_clear;
    logic                limit_event;
  } pcr_state_t;

  pcr_state_t s_q;
  pcr_state_t s_d;

  // Trim code to signed offset in microvolts. Code 100000 is the first positive
  // step, so the positive side cannot reach 32 steps and stops at 31.
  function automatic logic signed [15:0] pcr_zc_uv(input logic [5:0] code);
    logic [15:0] mag;
    logic [15:0] prod;
    mag = {11'h000, code[4:0]};
    if (code[ZC_SIGN_BIT] && (code[4:0] == 5'h00)) begin
      mag = 16'h0001;
    end
    prod = mag * ZC_STEP_UV;
    pcr_zc_uv = code[ZC_SIGN_BIT] ? $signed(prod) : -$signed(prod);
  endfunction : pcr_zc_uv

  // Three-bit threshold code to signed shift. Codes 1..3 go up when low_up is
  // set and down otherwise; codes 5..7 go the other way; codes 0 and 4 give zero.
  function automatic logic signed [11:0] pcr_step_mv(input logic [2:0] code,
                                                     input logic       low_up);
    logic [11:0] mag;
    logic        up;
    mag = {10'h000, code[1:0]} * THR_STEP_MV;
    up  = code[2] ? !low_up : low_up;
    pcr_step_mv = up ? $signed(mag) : -$signed(mag);
  endfunction : pcr_step_mv

  // Next-state logic: bus writes and reads, then every derived output.
  always_comb begin
    logic              writable;
    logic              wr_hit;
    logic signed [12:0] sense_diff;
    logic signed [11:0] ov_shift;
    logic signed [11:0] uv_shift;
    writable   = 1'b0;
    wr_hit     = 1'b0;
    sense_diff = 13'sh0000;
    ov_shift   = 12'sh000;
    uv_shift   = 12'sh000;
    s_d        = s_q;

    // The lock freezes the bank except the clear trigger, which stays live.
    writable = !reg_lock || (reg_addr == CLEAR_ADDR);
    wr_hit   = reg_wr_en && writable;
    s_d.status_clear = 1'b0;

    // Only implemented bits are stored; reserved bits drop on the floor.
    if (wr_hit && (reg_addr == ZC_TRIM_ADDR)) begin
      s_d.zc_trim = reg_wdata[5:0];
    end else if (wr_hit && (reg_addr == GATE_CFG_ADDR)) begin
      s_d.gate_code = reg_wdata[GATE_CODE_LSB +: 5];
      s_d.gate_en   = reg_wdata[GATE_EN_BIT];
    end else if (wr_hit && (reg_addr == OV_CFG_ADDR)) begin
      s_d.ov_code = reg_wdata[2:0];
    end else if (wr_hit && (reg_addr == UV_CFG_ADDR)) begin
      s_d.uv_code = reg_wdata[2:0];
    end else if (wr_hit && (reg_addr == TEMP_WARN_ADDR)) begin
      s_d.temp_thr = reg_wdata;
    end else if (wr_hit && (reg_addr == CLEAR_ADDR)) begin
      s_d.clear_bit = reg_wdata[CLEAR_BIT];
      // Only the rising edge of the stored bit clears; rewriting 1 does nothing.
      s_d.status_clear = reg_wdata[CLEAR_BIT] && !s_q.clear_bit;
    end else if (wr_hit && (reg_addr == AUX_CFG_ADDR)) begin
      s_d.aux_timer   = reg_wdata[AUX_TIMER_BIT];
      s_d.aux_source  = reg_wdata[AUX_SOURCE_BIT];
      s_d.aux_trigger = reg_wdata[AUX_TRIGGER_BIT];
    end

    // Reads return the value before a write in the same cycle; unmapped reads zero.
    s_d.rd_valid = reg_rd_en;
    s_d.rdata    = s_q.rdata;
    if (reg_rd_en) begin
      if (reg_addr == ZC_TRIM_ADDR) begin
        s_d.rdata = {2'h0, s_q.zc_trim} & ZC_TRIM_MASK;
      end else if (reg_addr == GATE_CFG_ADDR) begin
        s_d.rdata = {2'h0, s_q.gate_code, s_q.gate_en} & GATE_CFG_MASK;
      end else if (reg_addr == OV_CFG_ADDR) begin
        s_d.rdata = {5'h00, s_q.ov_code} & OV_CFG_MASK;
      end else if (reg_addr == UV_CFG_ADDR) begin
        s_d.rdata = {5'h00, s_q.uv_code} & UV_CFG_MASK;
      end else if (reg_addr == TEMP_WARN_ADDR) begin
        s_d.rdata = s_q.temp_thr & TEMP_WARN_MASK;
      end else if (reg_addr == CLEAR_ADDR) begin
        s_d.rdata = {7'h00, s_q.clear_bit} & CLEAR_MASK;
      end else if (reg_addr == AUX_CFG_ADDR) begin
        s_d.rdata = {4'h0, s_q.aux_timer, s_q.aux_source, s_q.aux_trigger, 1'b0}
                    & AUX_CFG_MASK;
      end else begin
        s_d.rdata = 8'h00;
      end
    end

    // Derived codes follow the new field values so they move on the write edge.
    s_d.zc_offset_uv = pcr_zc_uv(s_d.zc_trim);
    s_d.gate_mv = {6'h00, s_d.gate_code} * GATE_STEP_MV + GATE_BASE_MV;

    ov_shift = pcr_step_mv(s_d.ov_code, 1'b1);
    s_d.ov_clamped = (s_d.ov_code == OV_CLAMP_CODE);
    if (s_d.ov_clamped) begin
      s_d.ov_typ_mv = OV_CLAMP_MV;
      s_d.ov_min_mv = OV_CLAMP_MV;
    end else begin
      s_d.ov_typ_mv = OV_TYP_MV + ov_shift;
      s_d.ov_min_mv = OV_MIN_MV + ov_shift;
    end

    uv_shift = pcr_step_mv(s_d.uv_code, 1'b0);
    s_d.uv_enable   = (s_d.uv_code != UV_OFF_CODE);
    s_d.uv_typ_mv   = UV_TYP_MV + uv_shift;
    s_d.uv_bound_mv = UV_BOUND_MV + uv_shift;

    // Warning level only; whether it sits below the fault level is software's concern.
    s_d.temp_mv = {4'h0, s_d.temp_thr} * TEMP_STEP_MV;
    s_d.temp_warning = (power_stage_temp_monitor_code >= s_q.temp_thr);

    // The gate works from the configuration in force this cycle, one cycle of latency.
    s_d.gate_active = s_q.gate_en && (vout_rel_diff_amp_output_mv < s_q.gate_mv);
    s_d.phase_limit = s_d.gate_active ? '0 : per_phase_current_limit_raw;
    if (s_q.gate_en && (vout_rel_diff_amp_output_mv < s_q.gate_mv)) begin
      s_d.phase_limit = '0;
    end

    // Both trigger modes are evaluated on signed millivolts to keep the difference honest.
    sense_diff = $signed({1'b0, current_sense_reference_mv})
               - $signed({1'b0, current_sense_amp_out_mv});
    if (s_q.aux_trigger) begin
      s_d.limit_event = (sense_diff > LIMIT_DIFF_MV);
    end else begin
      s_d.limit_event = ($signed({1'b0, current_sense_amp_out_mv}) < LIMIT_LOW_MV);
    end
  end

  // State register with synchronous reset to the documented defaults.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q              <= '0;
      s_q.zc_trim      <= ZC_TRIM_RST[5:0];
      s_q.gate_code    <= GATE_CFG_RST[5:1];
      s_q.gate_en      <= GATE_CFG_RST[0];
      s_q.ov_code      <= OV_CFG_RST[2:0];
      s_q.uv_code      <= UV_CFG_RST[2:0];
      s_q.temp_thr     <= TEMP_WARN_RST;
      s_q.clear_bit    <= CLEAR_RST[0];
      s_q.aux_timer    <= AUX_CFG_RST[3];
      s_q.aux_source   <= AUX_CFG_RST[2];
      s_q.aux_trigger  <= AUX_CFG_RST[1];
      s_q.gate_mv      <= GATE_BASE_MV;
      s_q.ov_typ_mv    <= OV_TYP_MV;
      s_q.ov_min_mv    <= OV_MIN_MV;
      s_q.uv_typ_mv    <= UV_TYP_MV;
      s_q.uv_bound_mv  <= UV_BOUND_MV;
      s_q.uv_enable    <= 1'b1;
      s_q.temp_mv      <= {4'h0, TEMP_WARN_RST} * TEMP_STEP_MV;
    end else begin
      s_q <= s_d;
    end
  end

  // Every output is a field of the state register.
  assign reg_rdata                        = s_q.rdata;
  assign reg_rd_valid                     = s_q.rd_valid;
  assign zero_cross_detector_offset_uv    = s_q.zc_offset_uv;
  assign min_vout_limit_gate_mv           = s_q.gate_mv;
  assign min_vout_limit_gate_active       = s_q.gate_active;
  assign per_phase_current_limit          = s_q.phase_limit;
  assign overvoltage_protection_typ_mv    = s_q.ov_typ_mv;
  assign overvoltage_protection_min_mv    = s_q.ov_min_mv;
  assign overvoltage_protection_clamped   = s_q.ov_clamped;
  assign undervoltage_protection_typ_mv   = s_q.uv_typ_mv;
  assign undervoltage_protection_bound_mv = s_q.uv_bound_mv;
  assign undervoltage_protection_enable   = s_q.uv_enable;
  assign power_stage_temp_warn_mv         = s_q.temp_mv;
  assign power_stage_temp_warning         = s_q.temp_warning;
  assign overcurrent_limit_status_clear   = s_q.status_clear;
  assign ultrasonic_timer_enable          = s_q.aux_timer;
  assign settings_from_i2c                = s_q.aux_source;
  assign limit_trigger_select             = s_q.aux_trigger;
  assign current_limit_event              = s_q.limit_event;

  // Checks on the registered behaviour.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence seq_clear_rise;
    reg_wr_en && (reg_addr == CLEAR_ADDR) && reg_wdata[0] && !s_q.clear_bit;
  endsequence

  sequence seq_clear_pulse;
    overcurrent_limit_status_clear ##1 !overcurrent_limit_status_clear;
  endsequence

  AST_ZC_SIGN: assert property (
    (s_q.zc_trim[5] |-> zero_cross_detector_offset_uv > 0) and
    ((s_q.zc_trim == 6'h00) |-> zero_cross_detector_offset_uv == 0))
    else $error("Trim offset sign or zero point wrong.");

  AST_GATE_MAP: assert property (
    min_vout_limit_gate_mv == {6'h00, s_q.gate_code} * GATE_STEP_MV + GATE_BASE_MV)
    else $error("Gate threshold mapping wrong.");

  AST_GATE_OFF: assert property (
    !$past(s_q.gate_en) |-> !min_vout_limit_gate_active)
    else $error("Gate active while disabled.");

  AST_GATE_SUPPRESS: assert property (
    (s_q.gate_en && (vout_rel_diff_amp_output_mv < s_q.gate_mv))
      |=> min_vout_limit_gate_active && (per_phase_current_limit == '0))
    else $error("Per-phase limit not suppressed below threshold.");

  AST_OV_DEFAULT: assert property (
    (s_q.ov_code == 3'h0) |-> (overvoltage_protection_typ_mv == OV_TYP_MV) &&
                              (overvoltage_protection_min_mv == OV_MIN_MV))
    else $error("Over-voltage default trip wrong.");

  AST_OV_CLAMP: assert property (
    (s_q.ov_code == OV_CLAMP_CODE) |-> overvoltage_protection_clamped &&
                                       (overvoltage_protection_typ_mv == OV_CLAMP_MV))
    else $error("Over-voltage clamp not applied.");

  AST_OV_STEP: assert property (
    (s_q.ov_code == 3'h7) |-> (overvoltage_protection_typ_mv == OV_TYP_MV - 12'sh096))
    else $error("Over-voltage step wrong.");

  AST_UV_STEP: assert property (
    (undervoltage_protection_enable == (s_q.uv_code != UV_OFF_CODE)) and
    ((s_q.uv_code == 3'h1) |-> (undervoltage_protection_typ_mv == UV_TYP_MV - 12'sh032)))
    else $error("Under-voltage code decode wrong.");

  AST_TEMP_SCALE: assert property (
    power_stage_temp_warn_mv == {s_q.temp_thr, 3'b000})
    else $error("Temperature warning scale wrong.");

  AST_CLEAR_PULSE: assert property (
    seq_clear_rise |=> seq_clear_pulse)
    else $error("Clear pulse missing or too long.");

  // Any locked write outside the clear register must leave the over-voltage code and the gate fields alone.
  AST_LOCK_HOLD: assert property (
    (reg_wr_en && reg_lock && (reg_addr != CLEAR_ADDR)) |=> $stable(s_q.ov_code)
      && $stable(s_q.gate_code) && $stable(s_q.gate_en))
    else $error("Locked register accepted a write.");

  AST_AUX_RESERVED: assert property (
    (reg_rd_en && (reg_addr == AUX_CFG_ADDR)) |=> reg_rd_valid && (reg_rdata[7:4] == 4'h0)
      && !reg_rdata[0])
    else $error("Reserved auxiliary bits read nonzero.");

  AST_UV_DEFAULT: assert property (
    (s_q.uv_code == 3'h0) |-> (undervoltage_protection_typ_mv == UV_TYP_MV) &&
                              (undervoltage_protection_bound_mv == UV_BOUND_MV))
    else $error("Under-voltage default trip wrong.");

  // Low-level mode must flag the event one cycle after the sense output drops.
  AST_LIMIT_LOW: assert property (
    (!limit_trigger_select && ($signed({1'b0, current_sense_amp_out_mv}) < LIMIT_LOW_MV))
      |=> current_limit_event)
    else $error("Current-limit event missing in low-level mode.");

endmodule : pcr_protection_config_registers

// File: verif/test_protection_config_registers.sv
// Self-checking testbench for the protection configuration register bank.
`timescale 1ns/1ps

module test_protection_config_registers
  import pcr_pkg::*;
();
  localparam int NPH = 8;

  logic                  clk;
  logic                  reset_n;
  logic                  reg_wr_en;
  logic                  reg_rd_en;
  logic [7:0]            reg_addr;
  logic [7:0]            reg_wdata;
  logic                  reg_lock;
  logic [10:0]           vout_mv;
  logic [NPH-1:0]        raw_lim;
  logic [7:0]            temp_code;
  logic [11:0]           amp_mv;
  logic [11:0]           ref_mv;
  logic [7:0]            reg_rdata;
  logic                  reg_rd_valid;
  logic signed [15:0]    zc_uv;
  logic [10:0]           gate_mv;
  logic                  gate_act;
  logic [NPH-1:0]        ph_lim;
  logic signed [11:0]    ov_typ;
  logic signed [11:0]    ov_min;
  logic                  ov_clamp;
  logic signed [11:0]    uv_typ;
  logic signed [11:0]    uv_bnd;
  logic                  uv_en;
  logic [11:0]           warn_mv;
  logic                  warn;
  logic                  clr_pulse;
  logic                  timer_en;
  logic                  from_i2c;
  logic                  trig_sel;
  logic                  lim_event;
  int                    failures = 0;
  int                    num_checks = 0;

  pcr_protection_config_registers #(.NPHASE(NPH)) dut (
    .clk(clk), .reset_n(reset_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_lock(reg_lock),
    .vout_rel_diff_amp_output_mv(vout_mv), .per_phase_current_limit_raw(raw_lim),
    .power_stage_temp_monitor_code(temp_code), .current_sense_amp_out_mv(amp_mv),
    .current_sense_reference_mv(ref_mv), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
    .zero_cross_detector_offset_uv(zc_uv), .min_vout_limit_gate_mv(gate_mv),
    .min_vout_limit_gate_active(gate_act), .per_phase_current_limit(ph_lim),
    .overvoltage_protection_typ_mv(ov_typ), .overvoltage_protection_min_mv(ov_min),
    .overvoltage_protection_clamped(ov_clamp), .undervoltage_protection_typ_mv(uv_typ),
    .undervoltage_protection_bound_mv(uv_bnd), .undervoltage_protection_enable(uv_en),
    .power_stage_temp_warn_mv(warn_mv), .power_stage_temp_warning(warn),
    .overcurrent_limit_status_clear(clr_pulse), .ultrasonic_timer_enable(timer_en),
    .settings_from_i2c(from_i2c), .limit_trigger_select(trig_sel),
    .current_limit_event(lim_event));

  // Free-running 100 MHz clock.
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // One comparison; signed outputs sign-extend into the 32-bit argument.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  // Inputs move 1 ns after the edge so the design never races the bench.
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  // An idle edge first keeps a strobe from being lowered and raised in one step.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    reg_wr_en = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    tick();
    reg_wr_en = 1'b0;
  endtask : wr

  // Read with fixed latency of one cycle, then compare the byte.
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    tick();
    reg_rd_en = 1'b1;
    reg_addr  = a;
    tick();
    reg_rd_en = 1'b0;
    chk("rd_valid", 1, reg_rd_valid);
    chk(what, exp, reg_rdata);
  endtask : rd_chk

  task automatic sc_reset();
    chk("gate_mv", 215, gate_mv);
    chk("gate_act", 0, gate_act);
    chk("ov_typ", 600, ov_typ);
    chk("ov_min", 500, ov_min);
    chk("uv_typ", -500, uv_typ);
    chk("uv_bnd", -400, uv_bnd);
    chk("warn_mv", 2040, warn_mv);
    chk("aux", 0, {timer_en, from_i2c, trig_sel});
    rd_chk("zc_rst", ZC_TRIM_ADDR, 8'h00);
    rd_chk("gate_rst", GATE_CFG_ADDR, 8'h00);
    rd_chk("temp_rst", TEMP_WARN_ADDR, 8'hff);
    rd_chk("aux_rst", AUX_CFG_ADDR, 8'h00);
    rd_chk("unmapped", 8'h54, 8'h00);
    tick();
    chk("rd_valid_drop", 0, reg_rd_valid);
  endtask : sc_reset

  task automatic sc_trim();
    logic [7:0] tc[5] = '{8'h3f, 8'h20, 8'h01, 8'h1f, 8'h00};
    int         te[5] = '{18600, 600, -600, -18600, 0};
    for (int i = 0; i < 5; i++) begin
      wr(ZC_TRIM_ADDR, tc[i]);
      chk("zc_uv", te[i], zc_uv);
    end
  endtask : sc_trim

  task automatic sc_gate();
    raw_lim = 8'ha5;
    wr(GATE_CFG_ADDR, 8'h3f);
    chk("gate_mv", 1300, gate_mv);
    vout_mv = 11'd1299;
    tick();
    chk("gate_act", 1, gate_act);
    chk("ph_lim", 0, ph_lim);
    vout_mv = 11'd1300;
    tick();
    chk("ph_lim", 8'ha5, ph_lim);
    wr(GATE_CFG_ADDR, 8'h3e);
    vout_mv = 11'd100;
    tick();
    chk("ph_lim_off", 8'ha5, ph_lim);
    wr(GATE_CFG_ADDR, 8'h03);
    chk("gate_mv", 250, gate_mv);
    vout_mv = 11'd249;
    tick();
    chk("ph_lim", 0, ph_lim);
  endtask : sc_gate

  task automatic sc_ov_uv();
    int sh;
    for (int c = 0; c < 8; c++) begin
      wr(OV_CFG_ADDR, 8'(c));
      wr(UV_CFG_ADDR, 8'(c));
      sh = (c < 4) ? c * 50 : (4 - c) * 50;
      chk("ov_typ", (c == 4) ? 2000 : 600 + sh, ov_typ);
      chk("ov_min", (c == 4) ? 2000 : 500 + sh, ov_min);
      chk("ov_clamp", (c == 4), ov_clamp);
      chk("uv_typ", -500 - sh, uv_typ);
      chk("uv_bnd", -400 - sh, uv_bnd);
      chk("uv_en", (c != 4), uv_en);
    end
  endtask : sc_ov_uv

  task automatic sc_temp();
    wr(TEMP_WARN_ADDR, 8'h10);
    chk("warn_mv", 128, warn_mv);
    temp_code = 8'h10;
    tick();
    chk("warn", 1, warn);
    temp_code = 8'h0f;
    tick();
    chk("warn", 0, warn);
  endtask : sc_temp

  task automatic sc_aux();
    wr(AUX_CFG_ADDR, 8'h08);
    chk("aux", 3'b100, {timer_en, from_i2c, trig_sel});
    wr(AUX_CFG_ADDR, 8'h04);
    chk("aux", 3'b010, {timer_en, from_i2c, trig_sel});
    wr(AUX_CFG_ADDR, 8'h00);
    amp_mv = 12'd224;
    tick();
    chk("event_low", 1, lim_event);
    amp_mv = 12'd225;
    tick();
    chk("event_low", 0, lim_event);
    wr(AUX_CFG_ADDR, 8'h02);
    chk("trig_sel", 1, trig_sel);
    ref_mv = 12'd1300;
    amp_mv = 12'd299;
    tick();
    chk("event_diff", 1, lim_event);
    amp_mv = 12'd300;
    tick();
    chk("event_diff", 0, lim_event);
  endtask : sc_aux

  // A repeated 1 must not pulse again; the lock must spare only the clear register.
  task automatic sc_clear_lock();
    wr(CLEAR_ADDR, 8'h00);
    chk("clr", 0, clr_pulse);
    wr(CLEAR_ADDR, 8'h01);
    chk("clr", 1, clr_pulse);
    tick();
    chk("clr_drop", 0, clr_pulse);
    wr(CLEAR_ADDR, 8'h01);
    chk("clr_again", 0, clr_pulse);
    reg_lock = 1'b1;
    wr(OV_CFG_ADDR, 8'h04);
    chk("ov_locked", 0, ov_clamp);
    rd_chk("ov_locked", OV_CFG_ADDR, 8'h07);
    wr(CLEAR_ADDR, 8'h00);
    wr(CLEAR_ADDR, 8'h01);
    chk("clr_locked", 1, clr_pulse);
    reg_lock = 1'b0;
  endtask : sc_clear_lock

  task automatic sc_reserved();
    logic [7:0] ad[7] = '{ZC_TRIM_ADDR, GATE_CFG_ADDR, OV_CFG_ADDR, UV_CFG_ADDR,
                          TEMP_WARN_ADDR, CLEAR_ADDR, AUX_CFG_ADDR};
    logic [7:0] mk[7] = '{8'h3f, 8'h3f, 8'h07, 8'h07, 8'hff, 8'h01, 8'h0e};
    for (int i = 0; i < 7; i++) begin
      wr(ad[i], 8'hff);
      rd_chk("reserved", ad[i], mk[i]);
    end
    wr(8'h54, 8'h5a);
    rd_chk("unmapped", 8'h54, 8'h00);
  endtask : sc_reserved

  task automatic give_verdict();
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  // Main sequence; every wait is a fixed latency, so nothing can hang.
  initial begin
    reset_n   = 1'b0;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_lock  = 1'b0;
    vout_mv   = 11'd0;
    raw_lim   = '0;
    temp_code = 8'h00;
    amp_mv    = 12'd500;
    ref_mv    = 12'd0;
    repeat (16) tick();
    reset_n = 1'b1;
    sc_reset();
    sc_trim();
    sc_gate();
    sc_ov_uv();
    sc_temp();
    sc_aux();
    sc_clear_lock();
    sc_reserved();
    give_verdict();
  end

endmodule : test_protection_config_registers
